// >>> rtl/irs_consts.vh
// constants shared by the input port resampler files
`ifndef IRS_CONSTS_VH
`define IRS_CONSTS_VH

// ----------------------------------------------------------------
// register indices on the plain register port
// ----------------------------------------------------------------
`define IRS_ADDR_W 4
`define IRS_REG_CTRL 4'h0
`define IRS_REG_SSEL 4'h1
`define IRS_REG_SYNC 4'h2
`define IRS_REG_CADDR 4'h3
`define IRS_REG_CDATA 4'h4
`define IRS_REG_STAT 4'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IRS_CTRL_ENA 0
`define IRS_CTRL_DEC15 1
`define IRS_CTRL_BYP 2
`define IRS_CTRL_RATE_LO 3
`define IRS_CTRL_RATE_HI 4
`define IRS_CTRL_REAL 5
`define IRS_SSEL_RXIN_LO 0
`define IRS_SSEL_RESAMP_LO 4
`define IRS_SSEL_FIFO_LO 8
`define IRS_SYNC_SW 0
`define IRS_STAT_LVL_LO 0
`define IRS_STAT_LVL_HI 3
`define IRS_STAT_OVF 4
`define IRS_STAT_UDF 5

// ----------------------------------------------------------------
// widths, depths and preset values
// ----------------------------------------------------------------
`define IRS_IN_W 16
`define IRS_COEF_W 18
`define IRS_OUT_W 18
`define IRS_TAPS 24
`define IRS_CIDX_W 5
`define IRS_FIFO_DEPTH 8
`define IRS_FIFO_AW 3
`define IRS_FIFO_PRESET 3'h4
`define IRS_RATE_W 2
`define IRS_SSEL_W 3
`define IRS_SYNC_PINS 5
`define IRS_GATE_SKIP 2'h3
`define IRS_SHIFT_D2 17
`define IRS_SHIFT_D15 16

`endif

// >>> rtl/irs_resamp.v
// one resampler channel: fs/4 mixer, 12-deep polyphase filter, decimator
`include "irs_consts.vh"

module irs_resamp #(
   parameter IN_W = `IRS_IN_W,
   parameter COEF_W = `IRS_COEF_W,
   parameter OUT_W = `IRS_OUT_W,
   parameter TAPS = `IRS_TAPS
) (
   // clock and reset
   input wire mclk_i,
   input wire rst_i,
   // configuration
   input wire decim15_i,
   input wire sync_i,
   input wire [TAPS*COEF_W-1:0] coef_i,
   // real input stream
   input wire [IN_W-1:0] sample_i,
   input wire sample_v_i,
   // complex output stream
   output reg [OUT_W-1:0] i_o,
   output reg [OUT_W-1:0] q_o,
   output reg out_v_o
);

   localparam LINE = TAPS / 2;
   localparam DW = IN_W + 1;
   localparam PW = DW + COEF_W;
   localparam ACC_W = PW + 4;

   reg [1:0] mix_q;
   reg [1:0] dec_q;
   reg calc_q;
   reg odd_q;
   reg [LINE*DW-1:0] dli_q;
   reg [LINE*DW-1:0] dlq_q;
   reg signed [DW-1:0] mi;
   reg signed [DW-1:0] mq;
   reg signed [ACC_W-1:0] acc_i;
   reg signed [ACC_W-1:0] acc_q;
   wire [LINE*PW-1:0] pi_flat;
   wire [LINE*PW-1:0] pq_flat;
   wire signed [DW-1:0] x_w = {sample_i[IN_W-1], sample_i};
   wire signed [DW-1:0] xn_w = -x_w;
   wire due_w = decim15_i ? (dec_q != 2'h2) : (dec_q == 2'h1);
   integer j;

   // ----------------------------------------------------------------
   // mix down by a quarter of the sample rate: cos takes 1,0,-1,0 and -sin 0,-1,0,1
   // ----------------------------------------------------------------
   always @* begin
      case (mix_q)
         2'h0: begin
            mi = x_w;
            mq = {DW{1'b0}};
         end
         2'h1: begin
            mi = {DW{1'b0}};
            mq = xn_w;
         end
         2'h2: begin
            mi = xn_w;
            mq = {DW{1'b0}};
         end
         default: begin
            mi = {DW{1'b0}};
            mq = x_w;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // phase, decimation and delay line; the sync pin aligns both phases
   // ----------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (rst_i || sync_i) begin
         mix_q <= 2'h0;
         dec_q <= 2'h0;
         calc_q <= 1'b0;
         odd_q <= 1'b0;
      end else begin
         calc_q <= sample_v_i && due_w;
         if (sample_v_i) begin
            mix_q <= mix_q + 2'h1;
            odd_q <= decim15_i && (dec_q == 2'h1);
            // 1.5 keeps two of every three inputs, 2 keeps one of two
            if ((decim15_i && dec_q == 2'h2) || (!decim15_i && dec_q != 2'h0)) begin
               dec_q <= 2'h0;
            end else begin
               dec_q <= dec_q + 2'h1;
            end
         end
      end
      if (rst_i) begin
         dli_q <= {LINE*DW{1'b0}};
         dlq_q <= {LINE*DW{1'b0}};
      end else if (sample_v_i) begin
         dli_q <= {dli_q[(LINE-1)*DW-1:0], mi};
         dlq_q <= {dlq_q[(LINE-1)*DW-1:0], mq};
      end
   end

   // ----------------------------------------------------------------
   // taps: by 2 uses coefficients 0..11, by 1.5 the even or odd half
   // of 24, which is the zero-stuffed 2x filter seen per phase
   // ----------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < LINE; k = k + 1) begin : g_tap
         // full-width index, so no bits are dropped before the slice below
         wire [31:0] ci = decim15_i ? (2 * k + odd_q) : k;
         wire signed [COEF_W-1:0] c = coef_i[ci*COEF_W +: COEF_W];
         wire signed [DW-1:0] di = dli_q[k*DW +: DW];
         wire signed [DW-1:0] dq = dlq_q[k*DW +: DW];
         wire signed [PW-1:0] pi = di * c;
         wire signed [PW-1:0] pq = dq * c;
         assign pi_flat[k*PW +: PW] = pi;
         assign pq_flat[k*PW +: PW] = pq;
      end
   endgenerate

   always @* begin
      acc_i = {ACC_W{1'b0}};
      acc_q = {ACC_W{1'b0}};
      for (j = 0; j < LINE; j = j + 1) begin
         acc_i = acc_i + $signed(pi_flat[j*PW +: PW]);
         acc_q = acc_q + $signed(pq_flat[j*PW +: PW]);
      end
   end

   // ----------------------------------------------------------------
   // output; no saturation, coefficient sets must keep unity gain
   // ----------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (rst_i) begin
         i_o <= {OUT_W{1'b0}};
         q_o <= {OUT_W{1'b0}};
         out_v_o <= 1'b0;
      end else begin
         out_v_o <= calc_q;
         if (calc_q) begin
            // one less shift at 1.5 makes up for the stuffed zeros
            if (decim15_i) begin
               i_o <= acc_i[`IRS_SHIFT_D15 +: OUT_W];
               q_o <= acc_q[`IRS_SHIFT_D15 +: OUT_W];
            end else begin
               i_o <= acc_i[`IRS_SHIFT_D2 +: OUT_W];
               q_o <= acc_q[`IRS_SHIFT_D2 +: OUT_W];
            end
         end
      end
   end

endmodule

// >>> rtl/irs_top.v
// input port resampler: input fifo, two resamplers and lane selectors
`include "irs_consts.vh"

module irs_top #(
   parameter IN_W = `IRS_IN_W,
   parameter COEF_W = `IRS_COEF_W,
   parameter OUT_W = `IRS_OUT_W,
   parameter TAPS = `IRS_TAPS
) (
   // clock and reset
   input wire mclk_i,
   input wire rst_i,
   // converter side
   input wire adc_clk_i,
   input wire [IN_W-1:0] rxin0_i,
   input wire [IN_W-1:0] rxin1_i,
   input wire [IN_W-1:0] rxin2_i,
   input wire [IN_W-1:0] rxin3_i,
   input wire [`IRS_SYNC_PINS-1:0] sync_pin_i,
   // register port
   input wire [`IRS_ADDR_W-1:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // distribution lanes
   output reg [OUT_W-1:0] lane0_o,
   output reg [OUT_W-1:0] lane1_o,
   output reg [OUT_W-1:0] lane2_o,
   output reg [OUT_W-1:0] lane3_o,
   output reg lane_v_o,
   output wire ddc_sync_o,
   output wire real_input_o
);

   localparam WW = 4 * IN_W;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg ena_q;
   reg dec15_q;
   reg byp_q;
   reg [`IRS_RATE_W-1:0] rate_q;
   reg real_q;
   reg [`IRS_SSEL_W-1:0] ssel_rxin_q;
   reg [`IRS_SSEL_W-1:0] ssel_resamp_q;
   reg [`IRS_SSEL_W-1:0] ssel_fifo_q;
   reg sw_sync_q;
   reg [`IRS_CIDX_W-1:0] caddr_q;
   reg [TAPS*COEF_W-1:0] coef_q;
   reg ovf_q;
   reg udf_q;

   // ----------------------------------------------------------------
   // synchronisers for everything from the converter side
   // ----------------------------------------------------------------
   reg [2:0] aclk_q;
   reg [WW-1:0] din_m_q;
   reg [WW-1:0] din_q;
   reg [`IRS_SYNC_PINS-1:0] spin_m_q;
   reg [`IRS_SYNC_PINS-1:0] spin_q;
   reg [`IRS_SYNC_PINS-1:0] spin_d_q;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         aclk_q <= 3'h0;
         din_m_q <= {WW{1'b0}};
         din_q <= {WW{1'b0}};
         spin_m_q <= {`IRS_SYNC_PINS{1'b0}};
         spin_q <= {`IRS_SYNC_PINS{1'b0}};
         spin_d_q <= {`IRS_SYNC_PINS{1'b0}};
      end else begin
         aclk_q <= {aclk_q[1:0], adc_clk_i};
         din_m_q <= {rxin3_i, rxin2_i, rxin1_i, rxin0_i};
         din_q <= din_m_q;
         spin_m_q <= sync_pin_i;
         spin_q <= spin_m_q;
         spin_d_q <= spin_q;
      end
   end

   // rising edge of the sampled converter clock, read from stage two on
   wire aclk_rise_w = aclk_q[1] && !aclk_q[2];
   wire [`IRS_SYNC_PINS-1:0] spin_rise_w = spin_q & ~spin_d_q;
   // sources: 0 never, 1 always, 2 software one-shot, 3..7 pin edges
   wire [7:0] sync_src_w = {spin_rise_w, sw_sync_q, 1'b1, 1'b0};
   wire sync_rxin_w = sync_src_w[ssel_rxin_q];
   wire sync_resamp_w = sync_src_w[ssel_resamp_q];
   wire sync_fifo_w = sync_src_w[ssel_fifo_q];

   assign ddc_sync_o = sync_rxin_w;
   assign real_input_o = real_q;

   // ----------------------------------------------------------------
   // fifo read rate and gating
   // ----------------------------------------------------------------
   reg [2:0] div_q;
   reg [1:0] gate_q;
   reg [2:0] div_mask;

   always @* begin
      case (rate_q)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   end

   wire gated_w = ena_q && dec15_q && (rate_q == 2'h0);
   wire rd_tick_w = ((div_q & div_mask) == 3'h0) &&
                    !(gated_w && gate_q == `IRS_GATE_SKIP);

   always @(posedge mclk_i) begin
      if (rst_i || sync_rxin_w) begin
         div_q <= 3'h0;
         gate_q <= 2'h0;
      end else begin
         div_q <= div_q + 3'h1;
         gate_q <= gate_q + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // eight-entry input fifo, written on converter clock edges
   // ----------------------------------------------------------------
   reg [WW-1:0] fifo_q [0:`IRS_FIFO_DEPTH-1];
   reg [`IRS_FIFO_AW-1:0] wr_ptr_q;
   reg [`IRS_FIFO_AW-1:0] rd_ptr_q;
   reg [`IRS_FIFO_AW:0] lvl_q;

   wire empty_w = (lvl_q == 4'h0);
   wire full_w = (lvl_q == `IRS_FIFO_DEPTH);
   wire push_w = aclk_rise_w && !byp_q && !full_w;
   wire pop_w = rd_tick_w && !byp_q && !empty_w;

   always @(posedge mclk_i) begin
      if (push_w) begin
         fifo_q[wr_ptr_q] <= din_q;
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         wr_ptr_q <= {`IRS_FIFO_AW{1'b0}};
         rd_ptr_q <= {`IRS_FIFO_AW{1'b0}};
         lvl_q <= 4'h0;
      end else if (sync_fifo_w) begin
         // preset depth: reads trail writes by half the fifo
         wr_ptr_q <= `IRS_FIFO_PRESET;
         rd_ptr_q <= {`IRS_FIFO_AW{1'b0}};
         lvl_q <= {1'b0, `IRS_FIFO_PRESET};
      end else begin
         if (push_w) begin
            wr_ptr_q <= wr_ptr_q + 3'h1;
         end
         if (pop_w) begin
            rd_ptr_q <= rd_ptr_q + 3'h1;
         end
         if (push_w && !pop_w) begin
            lvl_q <= lvl_q + 4'h1;
         end else if (pop_w && !push_w) begin
            lvl_q <= lvl_q - 4'h1;
         end
      end
   end

   // bypass takes the synchronised pins on every read tick
   wire [WW-1:0] word_w = byp_q ? din_q : fifo_q[rd_ptr_q];
   wire word_v_w = byp_q ? rd_tick_w : pop_w;
   wire ovf_set_w = aclk_rise_w && !byp_q && full_w;
   wire udf_set_w = rd_tick_w && !byp_q && empty_w;

   // ----------------------------------------------------------------
   // resamplers on ports 0 and 2 only, sharing one coefficient set
   // ----------------------------------------------------------------
   wire [OUT_W-1:0] ra_i;
   wire [OUT_W-1:0] ra_q;
   wire ra_v;
   wire [OUT_W-1:0] rc_i;
   wire [OUT_W-1:0] rc_q;
   wire rc_v;
   wire rs_v_w = word_v_w && ena_q;

   irs_resamp #(
      .IN_W(IN_W),
      .COEF_W(COEF_W),
      .OUT_W(OUT_W),
      .TAPS(TAPS)
   ) u_resamp_a (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .decim15_i(dec15_q),
      .sync_i(sync_resamp_w),
      .coef_i(coef_q),
      .sample_i(word_w[0 +: IN_W]),
      .sample_v_i(rs_v_w),
      .i_o(ra_i),
      .q_o(ra_q),
      .out_v_o(ra_v)
   );

   irs_resamp #(
      .IN_W(IN_W),
      .COEF_W(COEF_W),
      .OUT_W(OUT_W),
      .TAPS(TAPS)
   ) u_resamp_c (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .decim15_i(dec15_q),
      .sync_i(sync_resamp_w),
      .coef_i(coef_q),
      .sample_i(word_w[2*IN_W +: IN_W]),
      .sample_v_i(rs_v_w),
      .i_o(rc_i),
      .q_o(rc_q),
      .out_v_o(rc_v)
   );

   // ----------------------------------------------------------------
   // lane selectors
   // ----------------------------------------------------------------
   localparam PAD = OUT_W - IN_W;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         lane0_o <= {OUT_W{1'b0}};
         lane1_o <= {OUT_W{1'b0}};
         lane2_o <= {OUT_W{1'b0}};
         lane3_o <= {OUT_W{1'b0}};
         lane_v_o <= 1'b0;
      end else if (ena_q) begin
         lane_v_o <= ra_v;
         if (ra_v) begin
            lane0_o <= ra_q;
            lane1_o <= ra_i;
            lane2_o <= rc_q;
            lane3_o <= rc_i;
         end
      end else begin
         // raw samples sit in the top bits of the wider lane
         lane_v_o <= word_v_w;
         if (word_v_w) begin
            lane0_o <= {word_w[0 +: IN_W], {PAD{1'b0}}};
            lane1_o <= {word_w[IN_W +: IN_W], {PAD{1'b0}}};
            lane2_o <= {word_w[2*IN_W +: IN_W], {PAD{1'b0}}};
            lane3_o <= {word_w[3*IN_W +: IN_W], {PAD{1'b0}}};
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   wire wr_ctrl_w = reg_wr_i && reg_addr_i == `IRS_REG_CTRL;
   wire wr_cdata_w = reg_wr_i && reg_addr_i == `IRS_REG_CDATA;
   wire wr_stat_w = reg_wr_i && reg_addr_i == `IRS_REG_STAT;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         ena_q <= 1'b0;
         dec15_q <= 1'b0;
         byp_q <= 1'b0;
         rate_q <= 2'h0;
         real_q <= 1'b0;
         ssel_rxin_q <= 3'h0;
         ssel_resamp_q <= 3'h0;
         ssel_fifo_q <= 3'h0;
         sw_sync_q <= 1'b0;
         caddr_q <= 5'h00;
         ovf_q <= 1'b0;
         udf_q <= 1'b0;
      end else begin
         sw_sync_q <= reg_wr_i && reg_addr_i == `IRS_REG_SYNC && reg_wdata_i[`IRS_SYNC_SW];
         if (wr_ctrl_w) begin
            ena_q <= reg_wdata_i[`IRS_CTRL_ENA];
            dec15_q <= reg_wdata_i[`IRS_CTRL_DEC15];
            byp_q <= reg_wdata_i[`IRS_CTRL_BYP];
            rate_q <= reg_wdata_i[`IRS_CTRL_RATE_HI:`IRS_CTRL_RATE_LO];
            real_q <= reg_wdata_i[`IRS_CTRL_REAL];
         end
         if (reg_wr_i && reg_addr_i == `IRS_REG_SSEL) begin
            ssel_rxin_q <= reg_wdata_i[`IRS_SSEL_RXIN_LO +: `IRS_SSEL_W];
            ssel_resamp_q <= reg_wdata_i[`IRS_SSEL_RESAMP_LO +: `IRS_SSEL_W];
            ssel_fifo_q <= reg_wdata_i[`IRS_SSEL_FIFO_LO +: `IRS_SSEL_W];
         end
         if (reg_wr_i && reg_addr_i == `IRS_REG_CADDR) begin
            caddr_q <= reg_wdata_i[`IRS_CIDX_W-1:0];
         end else if (wr_cdata_w) begin
            caddr_q <= (caddr_q == TAPS - 1) ? 5'h00 : caddr_q + 5'h01;
         end
         // a new error in the clearing cycle stays set
         ovf_q <= ovf_set_w || (ovf_q && !(wr_stat_w && reg_wdata_i[`IRS_STAT_OVF]));
         udf_q <= udf_set_w || (udf_q && !(wr_stat_w && reg_wdata_i[`IRS_STAT_UDF]));
      end
   end

   // coefficient store, one word per tap
   genvar t;
   generate
      for (t = 0; t < TAPS; t = t + 1) begin : g_coef
         always @(posedge mclk_i) begin
            if (rst_i) begin
               coef_q[t*COEF_W +: COEF_W] <= {COEF_W{1'b0}};
            end else if (wr_cdata_w && caddr_q == t) begin
               coef_q[t*COEF_W +: COEF_W] <= reg_wdata_i[COEF_W-1:0];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // register reads, data valid the cycle after the strobe
   // ----------------------------------------------------------------
   wire [COEF_W-1:0] coef_rd_w = coef_q[caddr_q*COEF_W +: COEF_W];

   always @(posedge mclk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= 32'h00000000;
         case (reg_addr_i)
            `IRS_REG_CTRL: begin
               reg_rdata_o[`IRS_CTRL_ENA] <= ena_q;
               reg_rdata_o[`IRS_CTRL_DEC15] <= dec15_q;
               reg_rdata_o[`IRS_CTRL_BYP] <= byp_q;
               reg_rdata_o[`IRS_CTRL_RATE_HI:`IRS_CTRL_RATE_LO] <= rate_q;
               reg_rdata_o[`IRS_CTRL_REAL] <= real_q;
            end
            `IRS_REG_SSEL: begin
               reg_rdata_o[`IRS_SSEL_RXIN_LO +: `IRS_SSEL_W] <= ssel_rxin_q;
               reg_rdata_o[`IRS_SSEL_RESAMP_LO +: `IRS_SSEL_W] <= ssel_resamp_q;
               reg_rdata_o[`IRS_SSEL_FIFO_LO +: `IRS_SSEL_W] <= ssel_fifo_q;
            end
            `IRS_REG_CADDR: reg_rdata_o[`IRS_CIDX_W-1:0] <= caddr_q;
            `IRS_REG_CDATA: reg_rdata_o[COEF_W-1:0] <= coef_rd_w;
            `IRS_REG_STAT: begin
               reg_rdata_o[`IRS_STAT_LVL_HI:`IRS_STAT_LVL_LO] <= lvl_q;
               reg_rdata_o[`IRS_STAT_OVF] <= ovf_q;
               reg_rdata_o[`IRS_STAT_UDF] <= udf_q;
            end
            default: reg_rdata_o <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

endmodule

// >>> test/irs_adc_model.sv
// converter model: free-running sample clock and four parallel ports
module irs_adc_model #(
   parameter int HALF = 80
) (
   input wire logic [63:0] word_i,
   output logic adc_clk_o,
   output logic [63:0] rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // sample clock, slow enough for the edge detector
   // ----------------------------------------
   initial adc_clk_o = 1'b0;
   always #(HALF) adc_clk_o = ~adc_clk_o;
   // ports move on the falling edge so they sit still round the rising one
   initial rx_o = 64'h0;
   always @(negedge adc_clk_o) rx_o <= word_i;
endmodule

// >>> test/irs_top_props.sv
// port checker for the input port resampler
module irs_top_props #(
   parameter OUT_W = 18
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic [4:0] sync_pin_i,
   input wire logic [OUT_W-1:0] lane0_o,
   input wire logic [OUT_W-1:0] lane1_o,
   input wire logic [OUT_W-1:0] lane2_o,
   input wire logic [OUT_W-1:0] lane3_o,
   input wire logic lane_v_o,
   input wire logic ddc_sync_o,
   input wire logic real_input_o
);
   logic [4:0] ctrl_q;
   logic [2:0] lsel_q;
   logic [3:0] quiet_q;
   wire calm = quiet_q == 4'hF;
   // mode mirrored from writes; checks wait until a change has flushed through
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_q <= 5'h0;
         lsel_q <= 3'h0;
         quiet_q <= 4'h0;
      end else begin
         if (reg_wr_i && reg_addr_i == 4'h0) ctrl_q <= reg_wdata_i[4:0];
         if (reg_wr_i && reg_addr_i == 4'h1) lsel_q <= reg_wdata_i[2:0];
         if (reg_wr_i && reg_addr_i < 4'h3) quiet_q <= 4'h0;
         else if (!calm) quiet_q <= quiet_q + 4'h1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence s_ctrl_wr;
      reg_wr_i && reg_addr_i == 4'h0;
   endsequence
   sequence s_sw_sync;
      reg_wr_i && reg_addr_i == 4'h2 && reg_wdata_i[0] && lsel_q == 3'h2;
   endsequence
   a_real_flag_out: assert property (s_ctrl_wr |=> real_input_o == $past(reg_wdata_i[5]))
      else $error("real flag output differs from written value");
   a_sync_never: assert property (lsel_q == 3'h0 && calm |-> !ddc_sync_o)
      else $error("lane sync active with no source");
   a_sync_always: assert property (lsel_q == 3'h1 && calm |-> ddc_sync_o)
      else $error("lane sync low with the always source");
   a_sw_sync_pulse: assert property (s_sw_sync |-> ##[1:2] ddc_sync_o)
      else $error("software sync pulse missing");
   a_sync_pin: assert property (lsel_q == 3'h3 && $rose(sync_pin_i[0]) |-> ##[1:3] ddc_sync_o)
      else $error("pin sync edge not passed to lane sync");
   a_off_low_bits: assert property (lane_v_o && !ctrl_q[0] && calm |->
      {lane0_o[1:0], lane1_o[1:0], lane2_o[1:0], lane3_o[1:0]} == 8'h00)
      else $error("pass-through lanes carry low bits");
   a_half_rate: assert property (lane_v_o && ctrl_q[0] && calm |=> !lane_v_o)
      else $error("resampler output above half rate");
   a_rate_eighth: assert property (lane_v_o && ctrl_q[4:3] == 2'h3 && !ctrl_q[0] && calm
      |=> !lane_v_o [*7])
      else $error("lane valid faster than one in eight");
   a_lanes_hold: assert property (!lane_v_o |->
      $stable({lane0_o, lane1_o, lane2_o, lane3_o}))
      else $error("lanes moved without valid");
endmodule

bind irs_top irs_top_props #(.OUT_W(OUT_W)) i_irs_top_props (.mclk_i, .rst_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .sync_pin_i, .lane0_o, .lane1_o, .lane2_o, .lane3_o, .lane_v_o,
   .ddc_sync_o,
   .real_input_o);

// >>> test/irs_top_test.sv
// self-checking bench for the input port resampler
module irs_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [63:0] word = 64'h0;
   logic [4:0] spin = 5'h0;
   logic [63:0] rx;
   logic adc_clk;
   wire [31:0] reg_rdata_o;
   wire [17:0] lane0_o, lane1_o, lane2_o, lane3_o;
   wire lane_v_o, ddc_sync_o, real_input_o;
   int bad_count = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'h11;
   logic [63:0] rd_q[$];
   logic [71:0] lane_q[$];
   logic rd_seen = 1'b0;

   always #4 mclk_i = ~mclk_i;

   irs_adc_model i_irs_adc_model (.word_i(word), .adc_clk_o(adc_clk), .rx_o(rx));
   irs_top i_irs_top (.mclk_i(mclk_i), .rst_i(rst_i), .adc_clk_i(adc_clk),
      .rxin0_i(rx[15:0]), .rxin1_i(rx[31:16]), .rxin2_i(rx[47:32]), .rxin3_i(rx[63:48]),
      .sync_pin_i(spin), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .lane0_o(lane0_o), .lane1_o(lane1_o), .lane2_o(lane2_o), .lane3_o(lane3_o),
      .lane_v_o(lane_v_o), .ddc_sync_o(ddc_sync_o), .real_input_o(real_input_o));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // sign of the mixed stream depends on phase, so lanes are judged by size
   function automatic logic [31:0] mag(logic [17:0] v);
      return {14'h0, v[17] ? 18'h0 - v : v};
   endfunction
   task automatic chk(string name, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (e !== g) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   // note holds the mask above the expected bits
   task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] e);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      rd_q.push_back({m, e});
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------
   // monitor
   // ----------------------------------------
   always @(posedge mclk_i) begin
      logic [63:0] r;
      logic [71:0] l;
      rd_seen <= reg_rd_i;
      if (rd_seen && rd_q.size() > 0) begin
         r = rd_q.pop_front();
         chk("reg_rdata_o", r[31:0], reg_rdata_o & r[63:32]);
      end
      if (lane_v_o === 1'b1 && lane_q.size() > 0) begin
         l = lane_q.pop_front();
         chk("lane0_o", {14'h0, l[17:0]}, mag(lane0_o));
         chk("lane1_o", {14'h0, l[35:18]}, mag(lane1_o));
         chk("lane2_o", {14'h0, l[53:36]}, mag(lane2_o));
         chk("lane3_o", {14'h0, l[71:54]}, mag(lane3_o));
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] c;
      logic [63:0] v;
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'hFFFFFFFF, 32'h0);
      wr(4'h0, 32'h22);
      rd(4'h0, 32'h3F, 32'h22);
      rd(4'hA, 32'hFFFFFFFF, 32'h0);
      wr(4'h3, 32'h0);
      wr(4'h4, 32'h10000);
      wr(4'h3, 32'hB);
      wr(4'h4, 32'h10000);
      wr(4'h3, 32'h17);
      c = rnd() & 32'h3FFFF;
      wr(4'h4, c);
      rd(4'h4, 32'h3FFFF, 32'h10000);
      wr(4'h3, 32'h17);
      rd(4'h4, 32'h3FFFF, c);
      // resampler off: every rate with bypass, then the fifo at rate 3 and 0
      for (int m = 0; m < 6; m++) begin
         v = {rnd() & 32'h7FFF7FFF, rnd() & 32'h7FFF7FFF};
         word <= v;
         wr(4'h0, m < 4 ? {27'h0, m[1:0], 3'h4} : (m == 4 ? 32'h18 : 32'h0));
         repeat (300) @(posedge mclk_i);
         lane_q.push_back({v[63:48], 2'h0, v[47:32], 2'h0,
            v[31:16], 2'h0, v[15:0], 2'h0});
         repeat (100) @(posedge mclk_i);
      end
      rd(4'h5, 32'h20, 32'h20);
      // both resamplers, decimate by two, taps 0 and 11 at one half
      word <= {16'h0, 16'h0800, 16'h0, 16'h2000};
      wr(4'h1, 32'h20);
      wr(4'h0, 32'h01);
      wr(4'h2, 32'h1);
      repeat (300) @(posedge mclk_i);
      lane_q.push_back({18'h400, 18'h400, 18'h1000, 18'h1000});
      repeat (200) @(posedge mclk_i);
      wr(4'h0, 32'h03);
      repeat (300) @(posedge mclk_i);
      wr(4'h1, 32'h1);
      repeat (20) @(posedge mclk_i);
      wr(4'h1, 32'h2);
      wr(4'h2, 32'h1);
      // pin 0 as lane sync while the fifo source holds the preset depth
      wr(4'h1, 32'h103);
      spin <= 5'h01;
      rd(4'h5, 32'hF, 32'h4);
      spin <= 5'h00;
      wr(4'h1, 32'h0);
      repeat (20) @(posedge mclk_i);
      chk("lane queue", 32'h0, lane_q.size());
      summarize();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      summarize();
   end
endmodule
